//--- core/gps_pin_mux.sv
`timescale 1ns/100ps

module gps_pin_mux (
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic                    cmd_valid,
  input  wire gps_pkg::gps_cmd_s       cmd,
  output logic                         cmd_ready,
  output logic                         rsp_valid,
  output logic [7:0]                   rsp_data,
  output logic                         nv_rd_req,
  output logic [1:0]                   nv_rd_index,
  input  wire logic                    nv_rd_valid,
  input  wire logic [7:0]              nv_rd_data,
  output logic                         nv_wr_en,
  output logic [1:0]                   nv_wr_index,
  output logic [7:0]                   nv_wr_data,
  output logic                         load_done,
  input  wire gps_pkg::gps_alt_s       alt,
  input  wire logic [3:0]              pin_in,
  output logic [3:0]                   pin_out,
  output logic [3:0]                   pin_oe,
  output logic [3:0]                   gpio_in_level,
  output logic [2:0]                   analog_in_sel,
  output logic [1:0]                   analog_out_sel,
  output logic                         int_detect_en,
  output logic                         int_detect_in
);
  import gps_pkg::*;

  gps_state_e      state_reg;            // Load sequencer state.
  logic [1:0]      load_idx_reg;         // Byte being fetched from storage.
  gps_setting_s    work_reg [NUM_PINS];  // Working copy that steers the pins.
  gps_setting_s    nv_shadow_reg [NUM_PINS]; // Last known nonvolatile contents.
  logic [3:0]      pin_meta_reg;         // First synchroniser stage.
  logic [3:0]      pin_sync_reg;         // Second synchroniser stage.
  gps_drive_s      drive_next [NUM_PINS]; // Decoded drive of each pin.
  logic            accept;               // A command is taken this cycle.
  logic            wr_vol;               // Accepted working copy write.
  logic            wr_nv;                // Accepted nonvolatile write.
  gps_setting_s    cmd_setting;          // Command data with reserved bits cleared.

  // Reserved bits are forced to zero, so readback never shows them set.
  function automatic gps_setting_s clean(input logic [7:0] raw);
    clean = gps_setting_s'(raw & KEEP_MASK);
  endfunction

  // True when the code is not defined for that pin.
  function automatic logic is_reserved(input logic [1:0] idx, input logic [2:0] fn);
    logic [2:0] fmax;
    fmax = P23_FN_MAX;
    unique case (idx)
      PIN0_IDX: fmax = P0_FN_MAX;
      PIN1_IDX: fmax = P1_FN_MAX;
      PIN2_IDX: fmax = P23_FN_MAX;
      PIN3_IDX: fmax = P23_FN_MAX;
    endcase
    is_reserved = (fn > fmax);
  endfunction

  // Pin drive from a settings byte. Analog, interrupt and reserved choices
  // leave the digital driver off, so a bad code can never fight the board.
  function automatic gps_drive_s drive_of(input logic [1:0] idx,
                                          input gps_setting_s s,
                                          input gps_alt_s a);
    gps_drive_s d;
    d = '0;
    if (s.pin_function_select == FN_GPIO) begin
      d.oe  = (s.pin_direction == DIR_OUT);
      d.out = d.oe & s.default_output_level;
    end else if (is_reserved(idx, s.pin_function_select)) begin
      d = '0;
    end else begin
      unique case (idx)
        PIN0_IDX: begin
          // Suspend indicator is low while the bus is suspended.
          d.oe  = 1'b1;
          d.out = (s.pin_function_select == P0_SUSPEND) ? ~a.suspended : a.uart_rx_act;
        end
        PIN1_IDX: begin
          d.oe  = (s.pin_function_select == P1_CLK_OUT) ||
                  (s.pin_function_select == P1_UTX_LED);
          d.out = (s.pin_function_select == P1_CLK_OUT) ? a.clk_out :
                  (d.oe & a.uart_tx_act);
        end
        PIN2_IDX: begin
          d.oe  = (s.pin_function_select == P2_CONFIGURED);
          d.out = d.oe & a.configured;
        end
        PIN3_IDX: begin
          d.oe  = (s.pin_function_select == P3_BUS_LED);
          d.out = d.oe & a.bus_act;
        end
      endcase
    end
    drive_of = d;
  endfunction

  // Commands are held off until the working copy has been loaded.
  assign cmd_ready   = (state_reg == ST_RUN);
  assign accept      = cmd_valid & cmd_ready;
  assign wr_vol      = accept & cmd.write & ~cmd.nonvol;
  assign wr_nv       = accept & cmd.write & cmd.nonvol;
  assign cmd_setting = clean(cmd.data);
  assign nv_rd_req   = (state_reg == ST_LOAD_REQ);
  assign nv_rd_index = load_idx_reg;
  assign load_done   = (state_reg == ST_RUN);

  // Load sequencer: fetch each stored byte in pin order, one at a time.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg    <= ST_LOAD_REQ;
      load_idx_reg <= PIN0_IDX;
    end else begin
      unique case (state_reg)
        ST_LOAD_REQ: state_reg <= ST_LOAD_WAIT;
        ST_LOAD_WAIT: begin
          if (nv_rd_valid) begin
            if (load_idx_reg == LAST_IDX) begin
              state_reg <= ST_RUN;
            end else begin
              state_reg    <= ST_LOAD_REQ;
              load_idx_reg <= load_idx_reg + 2'h1;
            end
          end
        end
        ST_RUN: state_reg <= ST_RUN;
        default: state_reg <= ST_LOAD_REQ;
      endcase
    end
  end

  // Working copy: shipped values until storage answers, then host writes.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      work_reg[PIN0_IDX] <= gps_setting_s'(PIN0_FACTORY);
      work_reg[PIN1_IDX] <= gps_setting_s'(PIN1_FACTORY);
      work_reg[PIN2_IDX] <= gps_setting_s'(PIN2_FACTORY);
      work_reg[PIN3_IDX] <= gps_setting_s'(PIN3_FACTORY);
    end else if (state_reg == ST_LOAD_WAIT && nv_rd_valid) begin
      work_reg[load_idx_reg] <= clean(nv_rd_data);
    end else if (wr_vol) begin
      work_reg[cmd.index] <= cmd_setting;
    end
  end

  // Shadow of storage so reads of the nonvolatile copy answer at once.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        nv_shadow_reg[i] <= '0;
      end
    end else if (state_reg == ST_LOAD_WAIT && nv_rd_valid) begin
      nv_shadow_reg[load_idx_reg] <= clean(nv_rd_data);
    end else if (wr_nv) begin
      nv_shadow_reg[cmd.index] <= cmd_setting;
    end
  end

  // Storage write strobe; it leaves the pins alone until the next power-up.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      nv_wr_en    <= 1'b0;
      nv_wr_index <= PIN0_IDX;
      nv_wr_data  <= '0;
    end else begin
      nv_wr_en <= wr_nv;
      if (wr_nv) begin
        nv_wr_index <= cmd.index;
        nv_wr_data  <= cmd_setting;
      end
    end
  end

  // Every accepted command answers one cycle later with the byte it names.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      rsp_valid <= accept;
      if (accept) begin
        if (cmd.write) begin
          rsp_data <= cmd_setting;
        end else if (cmd.nonvol) begin
          rsp_data <= nv_shadow_reg[cmd.index];
        end else begin
          rsp_data <= work_reg[cmd.index];
        end
      end
    end
  end

  // Pins come from outside the clock domain; two flops before any use.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Decode all four pins from the working copy.
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      drive_next[i] = drive_of(2'(i), work_reg[i], alt);
    end
  end

  // Pin drivers are registered; the cost is one cycle of latency.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        pin_out[i] <= drive_next[i].out;
        pin_oe[i]  <= drive_next[i].oe;
      end
    end
  end

  // Side outputs: input levels, analog routing and the interrupt source.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      gpio_in_level  <= '0;
      analog_in_sel  <= '0;
      analog_out_sel <= '0;
      int_detect_en  <= 1'b0;
      int_detect_in  <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        gpio_in_level[i] <= pin_sync_reg[i] &
          (work_reg[i].pin_function_select == FN_GPIO) &
          (work_reg[i].pin_direction == DIR_IN);
      end
      analog_in_sel[0]  <= (work_reg[PIN1_IDX].pin_function_select == P1_ANALOG_IN);
      analog_in_sel[1]  <= (work_reg[PIN2_IDX].pin_function_select == P2_ANALOG_IN);
      analog_in_sel[2]  <= (work_reg[PIN3_IDX].pin_function_select == P3_ANALOG_IN);
      analog_out_sel[0] <= (work_reg[PIN2_IDX].pin_function_select == P2_ANALOG_OUT);
      analog_out_sel[1] <= (work_reg[PIN3_IDX].pin_function_select == P3_ANALOG_OUT);
      int_detect_en     <= (work_reg[PIN1_IDX].pin_function_select == P1_INT_DETECT);
      int_detect_in     <= pin_sync_reg[PIN1_IDX] &
                           (work_reg[PIN1_IDX].pin_function_select == P1_INT_DETECT);
    end
  end

  // Count of stored bytes received, only for the load check below.
  logic [2:0] load_cnt_reg;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      load_cnt_reg <= '0;
    end else if (state_reg == ST_LOAD_WAIT && nv_rd_valid) begin
      load_cnt_reg <= load_cnt_reg + 3'h1;
    end
  end

  a_load_all_bytes: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(load_done) |-> load_cnt_reg == 3'(NUM_PINS))
    else $error("run entered before four bytes loaded");

  a_gpio_out_level: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_vol && cmd.data[2:0] == FN_GPIO && !cmd.data[DIR_BIT] |-> ##2
      (pin_oe[$past(cmd.index, 2)] &&
       pin_out[$past(cmd.index, 2)] == $past(cmd.data[LEVEL_BIT], 2)))
    else $error("gpio output did not follow written level");

  a_gpio_in_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_vol && cmd.data[2:0] == FN_GPIO && cmd.data[DIR_BIT] |-> ##2
      !pin_oe[$past(cmd.index, 2)])
    else $error("gpio input pin is driven");

  a_reserved_quiet: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_vol && is_reserved(cmd.index, cmd.data[2:0]) |-> ##2
      !pin_oe[$past(cmd.index, 2)])
    else $error("reserved code drives pin");

  a_nv_write_strobe: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wr_nv |=> nv_wr_en && nv_wr_data == ($past(cmd.data) & KEEP_MASK))
    else $error("storage write not issued");

  a_rsvd_read_zero: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rsp_valid |-> rsp_data[7:5] == 3'h0)
    else $error("reserved bits read nonzero");

  a_suspend_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
    work_reg[PIN0_IDX].pin_function_select == P0_SUSPEND |=>
      pin_oe[0] && pin_out[0] == !$past(alt.suspended))
    else $error("suspend indicator wrong");

  a_int_detect_sel: assert property (@(posedge sys_clk) disable iff (!reset_n)
    work_reg[PIN1_IDX].pin_function_select == P1_INT_DETECT |=>
      int_detect_en && !pin_oe[1])
    else $error("interrupt detector not selected");

  a_dac_one_sel: assert property (@(posedge sys_clk) disable iff (!reset_n)
    work_reg[PIN2_IDX].pin_function_select == P2_ANALOG_OUT |=>
      analog_out_sel[0] && !pin_oe[2])
    else $error("analog out one not routed");

  a_bus_led_drive: assert property (@(posedge sys_clk) disable iff (!reset_n)
    work_reg[PIN3_IDX].pin_function_select == P3_BUS_LED |=>
      pin_oe[3] && pin_out[3] == $past(alt.bus_act))
    else $error("bus activity led wrong");

  a_shipped_pins: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_reg == ST_LOAD_REQ && load_idx_reg == PIN0_IDX |=>
      pin_oe == 4'hF && pin_out[2] == $past(alt.configured))
    else $error("shipped pin functions not active");

endmodule

//--- core/gps_pkg.sv
package gps_pkg;

  // Pin count and the width of a settings index.
  localparam int         NUM_PINS  = 4;
  localparam logic [1:0] PIN0_IDX  = 2'h0;
  localparam logic [1:0] PIN1_IDX  = 2'h1;
  localparam logic [1:0] PIN2_IDX  = 2'h2;
  localparam logic [1:0] PIN3_IDX  = 2'h3;
  localparam logic [1:0] LAST_IDX  = PIN3_IDX;

  // Field layout of a settings byte; bits 7-5 are reserved and kept at zero.
  localparam int         LEVEL_BIT = 4;
  localparam int         DIR_BIT   = 3;
  localparam logic [7:0] KEEP_MASK = 8'h1F;
  localparam logic       DIR_IN    = 1'b1;
  localparam logic       DIR_OUT   = 1'b0;

  // Function codes shared by every pin, then per pin.
  localparam logic [2:0] FN_GPIO       = 3'h0;
  localparam logic [2:0] P0_SUSPEND    = 3'h1;
  localparam logic [2:0] P0_URX_LED    = 3'h2;
  localparam logic [2:0] P0_FN_MAX     = 3'h2;
  localparam logic [2:0] P1_CLK_OUT    = 3'h1;
  localparam logic [2:0] P1_ANALOG_IN  = 3'h2;
  localparam logic [2:0] P1_UTX_LED    = 3'h3;
  localparam logic [2:0] P1_INT_DETECT = 3'h4;
  localparam logic [2:0] P1_FN_MAX     = 3'h4;
  localparam logic [2:0] P2_CONFIGURED = 3'h1;
  localparam logic [2:0] P2_ANALOG_IN  = 3'h2;
  localparam logic [2:0] P2_ANALOG_OUT = 3'h3;
  localparam logic [2:0] P3_BUS_LED    = 3'h1;
  localparam logic [2:0] P3_ANALOG_IN  = 3'h2;
  localparam logic [2:0] P3_ANALOG_OUT = 3'h3;
  localparam logic [2:0] P23_FN_MAX    = 3'h3;

  // Shipped settings of the four pins.
  localparam logic [7:0] PIN0_FACTORY = 8'h12;
  localparam logic [7:0] PIN1_FACTORY = 8'h13;
  localparam logic [7:0] PIN2_FACTORY = 8'h11;
  localparam logic [7:0] PIN3_FACTORY = 8'h11;

  // One settings byte.
  typedef struct packed {
    logic [2:0] rsvd;
    logic       default_output_level;
    logic       pin_direction;
    logic [2:0] pin_function_select;
  } gps_setting_s;

  // One configuration command from the USB command decoder.
  typedef struct packed {
    logic       write;
    logic       nonvol;
    logic [1:0] index;
    logic [7:0] data;
  } gps_cmd_s;

  // Indicator and clock sources of the alternate functions.
  typedef struct packed {
    logic suspended;
    logic configured;
    logic uart_rx_act;
    logic uart_tx_act;
    logic bus_act;
    logic clk_out;
  } gps_alt_s;

  // Drive of one pin.
  typedef struct packed {
    logic oe;
    logic out;
  } gps_drive_s;

  // Load sequencer states, Gray coded.
  typedef enum logic [1:0] {
    ST_LOAD_REQ  = 2'b00,
    ST_LOAD_WAIT = 2'b01,
    ST_RUN       = 2'b11
  } gps_state_e;

endpackage

//--- testbench/gps_nv_model.sv
`timescale 1ns/100ps

// Nonvolatile settings store on the far side of the load port.
// It keeps its contents across a reset, as real storage would.
module gps_nv_model #(
  parameter logic [7:0] INIT0 = 8'h00,
  parameter logic [7:0] INIT1 = 8'h00,
  parameter logic [7:0] INIT2 = 8'h00,
  parameter logic [7:0] INIT3 = 8'h00,
  parameter int         LAT   = 1
) (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       nv_rd_req,
  input  wire logic [1:0] nv_rd_index,
  output logic            nv_rd_valid,
  output logic [7:0]      nv_rd_data,
  input  wire logic       nv_wr_en,
  input  wire logic [1:0] nv_wr_index,
  input  wire logic [7:0] nv_wr_data
);
  logic [7:0] mem_reg [4];  // Stored settings bytes.
  logic [3:0] wait_reg;     // Cycles left before the answer.
  logic [1:0] idx_reg;      // Index of the pending fetch.

  // Start from the chosen contents and an idle answer port.
  initial begin
    mem_reg[0] = INIT0;
    mem_reg[1] = INIT1;
    mem_reg[2] = INIT2;
    mem_reg[3] = INIT3;
    nv_rd_valid = 1'b0;
    nv_rd_data = 8'h00;
    wait_reg = 4'h0;
    idx_reg = 2'h0;
  end

  // Answer each fetch after LAT cycles; storage writes only land in the array.
  // Outside the answer cycle the data toggles, so a stale byte is never seen.
  always @(posedge sys_clk) begin
    if (nv_wr_en) begin
      mem_reg[nv_wr_index] <= nv_wr_data;
    end
    nv_rd_valid <= 1'b0;
    if (!reset_n) begin
      wait_reg <= 4'h0;
    end else if (nv_rd_req) begin
      wait_reg <= LAT[3:0];
      idx_reg <= nv_rd_index;
    end else if (wait_reg != 4'h0) begin
      wait_reg <= wait_reg - 4'h1;
    end
    if (reset_n && !nv_rd_req && wait_reg == 4'h1) begin
      nv_rd_valid <= 1'b1;
      nv_rd_data <= mem_reg[idx_reg];
    end else begin
      nv_rd_data <= ~nv_rd_data;
    end
  end
endmodule

//--- testbench/gps_pin_function_settings_bench.sv
`timescale 1ns/100ps

// Self-checking bench for the pin function multiplexer.
module gps_pin_function_settings_bench;
  import gps_pkg::*;
  logic       sys_clk, reset_n, cmd_valid, cmd_ready, rsp_valid;
  logic       nv_rd_req, nv_rd_valid, nv_wr_en, load_done;
  logic       int_detect_en, int_detect_in;
  logic [7:0] rsp_data, nv_rd_data, nv_wr_data, rd_byte;
  logic [1:0] nv_rd_index, nv_wr_index, analog_out_sel;
  logic [3:0] pin_in, pin_out, pin_oe, gpio_in_level;
  logic [2:0] analog_in_sel;
  logic [10:0] wr_snap;  // Storage write strobe, index and data at the answer.
  gps_cmd_s   cmd;
  gps_alt_s   alt;
  int         n_mismatch, num_checks;

  gps_pin_mux DUT (.sys_clk(sys_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .nv_rd_req(nv_rd_req), .nv_rd_index(nv_rd_index), .nv_rd_valid(nv_rd_valid),
    .nv_rd_data(nv_rd_data), .nv_wr_en(nv_wr_en), .nv_wr_index(nv_wr_index),
    .nv_wr_data(nv_wr_data), .load_done(load_done), .alt(alt), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .gpio_in_level(gpio_in_level),
    .analog_in_sel(analog_in_sel), .analog_out_sel(analog_out_sel),
    .int_detect_en(int_detect_en), .int_detect_in(int_detect_in));

  // Slow storage, so the shipped settings stay visible while loading.
  gps_nv_model #(.INIT0(8'h10), .INIT1(8'h08), .INIT2(8'h03), .INIT3(8'hE1), .LAT(6)) NV (
    .sys_clk(sys_clk), .reset_n(reset_n), .nv_rd_req(nv_rd_req), .nv_rd_index(nv_rd_index),
    .nv_rd_valid(nv_rd_valid), .nv_rd_data(nv_rd_data), .nv_wr_en(nv_wr_en),
    .nv_wr_index(nv_wr_index), .nv_wr_data(nv_wr_data));

  // Free-running 200 MHz clock.
  always #2.5 sys_clk = ~sys_clk;

  // Count one comparison and report it at once if it misses.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Print the verdict and stop.
  task automatic summarize;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One command: held until taken, answer checked one cycle later, then pins settle.
  task automatic send(input logic wr, input logic nv, input logic [1:0] idx,
                      input logic [7:0] d);
    int k;
    k = 0;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd = '{write: wr, nonvol: nv, index: idx, data: d};
    while (cmd_ready !== 1'b1 && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    chk({7'h00, rsp_valid}, 8'h01);
    rd_byte = rsp_data;
    wr_snap = {nv_wr_en, nv_wr_index, nv_wr_data};
    @(negedge sys_clk);
  endtask

  // Hold reset for three cycles, release it off the sampling edge.
  task automatic do_reset;
    reset_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
  endtask

  // Wait for the load to finish, bounded so a stuck load is reported.
  task automatic wait_load;
    int k;
    k = 0;
    while (load_done !== 1'b1 && k < 200) begin
      @(negedge sys_clk);
      k++;
    end
    chk({7'h00, load_done}, 8'h01);
  endtask

  // Expected {oe, out, interrupt enable, analog in, analog out} of pin p.
  function automatic logic [7:0] exp_pin(input int p, input logic [7:0] b);
    logic oe, o, ie;
    logic [2:0] ai;
    logic [1:0] ao;
    {oe, o, ie, ai, ao} = 8'h00;
    case (b[2:0])
      3'h0: {oe, o} = {~b[3], b[4]};
      3'h1: begin
        oe = 1'b1;
        o = (p == 0) ? ~alt.suspended : (p == 1) ? alt.clk_out :
            (p == 2) ? alt.configured : alt.bus_act;
      end
      3'h2: if (p == 0) {oe, o} = {1'b1, alt.uart_rx_act}; else ai[p-1] = 1'b1;
      3'h3: if (p == 1) {oe, o} = {1'b1, alt.uart_tx_act}; else if (p > 1) ao[p-2] = 1'b1;
      3'h4: ie = (p == 1);
      default: oe = 1'b0;
    endcase
    return {oe, o & oe, ie, ai, ao};
  endfunction

  // Until the first stored byte lands, all pins run their shipped indicator functions.
  task automatic t_shipped;
    chk({pin_oe, pin_out}, 8'hF5);
    chk({7'h00, cmd_ready}, 8'h00);
    // The six-cycle store answers pin zero six edges after its fetch.
    // The fetch of pin one must follow at once, in pin order.
    repeat (7) @(negedge sys_clk);
    chk({5'h00, nv_rd_req, nv_rd_index}, 8'h05);
  endtask

  // Loaded bytes read back with reserved bits cleared and drive the pins.
  task automatic t_load;
    logic [7:0] exp [4];
    exp = '{8'h10, 8'h08, 8'h03, 8'h01};
    chk({pin_oe, pin_out & pin_oe}, 8'h91);
    for (int i = 0; i < 4; i++) begin
      send(1'b0, 1'b0, i[1:0], 8'h00);
      chk(rd_byte, exp[i]);
    end
  endtask

  // Every function code of every pin, including reserved ones, switches at once.
  task automatic t_mux;
    logic [7:0] b;
    for (int i = 0; i < 4; i++) send(1'b1, 1'b0, i[1:0], 8'h08);
    for (int p = 0; p < 4; p++) begin
      // Flip the pin levels so the pin under test reads high as a GPIO input.
      pin_in = ~pin_in;
      for (int v = 0; v < 10; v++) begin
        b = (v == 8) ? 8'h00 : (v == 9) ? 8'h08 : {3'h0, ~v[0], 1'b0, v[2:0]};
        send(1'b1, 1'b0, p[1:0], b);
        chk(rd_byte, b);
        chk({pin_oe[p], pin_out[p] & pin_oe[p], int_detect_en, analog_in_sel,
             analog_out_sel}, exp_pin(p, b));
        // Flip every indicator source, so a pin stuck at one level is caught.
        alt = gps_alt_s'(~alt);
        repeat (3) @(negedge sys_clk);
        chk({pin_oe[p], pin_out[p] & pin_oe[p], int_detect_en, analog_in_sel,
             analog_out_sel}, exp_pin(p, b));
        chk({6'h00, gpio_in_level[p], int_detect_in},
            {6'h00, pin_in[p] & (b == 8'h08), pin_in[1] & (p == 1 && b[2:0] == 3'h4)});
      end
    end
  endtask

  // A storage write leaves the pins alone and sets the next power-up.
  task automatic t_nvwrite;
    send(1'b1, 1'b1, 2'h2, 8'h10);
    chk({5'h00, wr_snap[10:8]}, 8'h06);
    chk(wr_snap[7:0], 8'h10);
    chk({7'h00, pin_oe[2]}, 8'h00);
    send(1'b0, 1'b1, 2'h2, 8'h00);
    chk(rd_byte, 8'h10);
    do_reset();
    wait_load();
    send(1'b0, 1'b0, 2'h2, 8'h00);
    chk(rd_byte, 8'h10);
    chk({6'h00, pin_oe[2], pin_out[2]}, 8'h03);
  endtask

  // Main sequence; every input has a value at time zero.
  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    pin_in = 4'hA;
    alt = '{suspended: 1'b1, configured: 1'b1, uart_rx_act: 1'b1, uart_tx_act: 1'b0,
            bus_act: 1'b0, clk_out: 1'b1};
    n_mismatch = 0;
    num_checks = 0;
    do_reset();
    t_shipped();
    wait_load();
    t_load();
    t_mux();
    t_nvwrite();
    summarize();
  end

  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    #(30000 * 5);
    n_mismatch++;
    summarize();
  end
endmodule
